// file: vipf_pkg.sv
// Constants, types and setup locations shared by both ends of the video input port.
// Assumes one 100 MHz system clock; all link pins are sampled on it.
// Notes on behaviour
// RULE_01 - Mode from location 0x01 bits 6:4, resets SD
// RULE_02 - Code 000 is SD only, 422 or RGB
// RULE_03 - Code 001 SDR, 010 DDR ED/HD only
// RULE_04 - SD: source drives 27 MHz clock, SD syncs; the source here divides the system clock by 4, giving 25 MHz
// RULE_05 - SD 8/10-bit interleaved on S, swap Y bus
// RULE_06 - SD 16/20-bit: luma S/Y, chroma Y/C
// RULE_07 - SD RGB enabled: R on S, G Y, B C
// RULE_08 - ED/HD RGB: R S, G Y, B C, SDR only
// RULE_09 - Narrow widths use only eight upper bits
// RULE_10 - Wide YCrCb and RGB need external syncs
// RULE_11 - SD format from location 0x88 bits 4:3
// RULE_12 - ED/HD width from location 0x33 bit 2
// RULE_13 - ED/HD 422 or 444 from 0x33 bit 6
// RULE_14 - ED/HD 444: luma Y, Cr S, Cb C
// RULE_15 - ED/HD SDR 422: luma Y, chroma C
// RULE_16 - DDR: luma one edge, chroma other, Y bus
// RULE_17 - Location 0x01 bits 2:1 pick luma edge
// RULE_18 - Program edge field 11 for sequence B
// RULE_19 - ED/HD: source drives clock and progressive syncs
// RULE_20 - DDR accepted only as 422 YCrCb
// RULE_21 - Codes 011, 100 simultaneous; SD primary, HD secondary
// RULE_22 - Code 111: interleaved Y bus, 54 MHz primary; the source here drives the primary at 25 MHz
// RULE_23 - SDR buses and syncs sampled on same rise

package vipf_pkg;

  // ****************************************************************
  // Setup locations and field positions
  // ****************************************************************
  localparam logic [7:0] LOC_INPUT_CTRL = 8'h01;
  localparam logic [7:0] LOC_HD_MODE = 8'h33;
  localparam logic [7:0] LOC_HD_RGB = 8'h35;
  localparam logic [7:0] LOC_SD_RGB = 8'h87;
  localparam logic [7:0] LOC_SD_MODE = 8'h88;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int MODE_MSB = 6;
  localparam int MODE_LSB = 4;
  localparam int BUS_SWAP_BIT = 7;
  localparam int EDGE_MSB = 2;
  localparam int EDGE_LSB = 1;
  localparam int HD_422_BIT = 6;
  localparam int HD_WIDE_BIT = 2;
  localparam int HD_RGB_BIT = 1;
  localparam int SD_RGB_BIT = 7;
  localparam int SD_WIDE_BIT = 4;
  localparam int SD_16_BIT = 3;

  // ****************************************************************
  // Input mode codes
  // ****************************************************************
  localparam logic [2:0] MODE_SD = 3'h0;
  localparam logic [2:0] MODE_HD_SDR = 3'h1;
  localparam logic [2:0] MODE_HD_DDR = 3'h2;
  localparam logic [2:0] MODE_SIM_SDR = 3'h3;
  localparam logic [2:0] MODE_SIM_DDR = 3'h4;
  localparam logic [2:0] MODE_ED54 = 3'h7;

  // ****************************************************************
  // Widths, link clock dividers, output formats
  // ****************************************************************
  localparam int BUS_W = 10;
  localparam logic [2:0] PRI_HALF = 3'h2;
  localparam logic [2:0] SEC_HALF = 3'h3;

  typedef enum logic [1:0] {
    FMT_INTERLEAVED = 2'h0,
    FMT_YC422 = 2'h1,
    FMT_YC444 = 2'h2,
    FMT_RGB = 2'h3
  } vipf_fmt_t;

  typedef enum logic [1:0] {
    DDR_WAIT_Y = 2'h1,
    DDR_HAVE_Y = 2'h2
  } vipf_ddr_t;

  // Narrow buses keep only the eight upper lines
  function automatic logic [BUS_W-1:0] trim(input logic [BUS_W-1:0] w, input logic wide);
    trim = wide ? w : {w[BUS_W-1:2], 2'h0}; // RULE_09
  endfunction

endpackage

// file: vipf_link_if.sv
// Pixel link between a video source and the encoder input port.
// Assumes both ends run on the same system clock; all pins are one-way.
`timescale 1ns/1ps
`default_nettype none

interface vipf_link_if;
  logic primary_pixel_clock_in;
  logic secondary_pixel_clock_in;
  logic [9:0] s_bus;
  logic [9:0] y_bus;
  logic [9:0] c_bus;
  logic sd_hsync_n;
  logic sd_vsync_n;
  logic pr_hsync_n;
  logic pr_vsync_n;
  logic pr_blank_n;

  modport dev (
    input primary_pixel_clock_in, secondary_pixel_clock_in, s_bus, y_bus, c_bus,
    input sd_hsync_n, sd_vsync_n, pr_hsync_n, pr_vsync_n, pr_blank_n
  );
  modport src (
    output primary_pixel_clock_in, secondary_pixel_clock_in, s_bus, y_bus, c_bus,
    output sd_hsync_n, sd_vsync_n, pr_hsync_n, pr_vsync_n, pr_blank_n
  );
endinterface

`default_nettype wire

// file: vipf_device.sv
// Encoder input port: samples the pixel link and routes the buses by input mode.
// Assumes link pins change only on system clock edges; setup is written per location.
`timescale 1ns/1ps
`default_nettype none

module vipf_device (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  vipf_link_if.dev link,
  input wire logic i_cfg_we,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [7:0] i_cfg_wdata,
  output logic [2:0] o_input_mode,
  output logic o_pix_valid,
  output logic [1:0] o_pix_fmt,
  output logic [9:0] o_comp0,
  output logic [9:0] o_comp1,
  output logic [9:0] o_comp2,
  output logic o_hsync_n,
  output logic o_vsync_n,
  output logic o_blank_n,
  output logic o_ext_sync_only,
  output logic o_aux_valid,
  output logic [9:0] o_aux_luma,
  output logic [9:0] o_aux_chroma
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] hd_mode;
    logic [7:0] hd_rgb;
    logic [7:0] sd_rgb;
    logic [7:0] sd_mode;
    logic pck;
    logic pck_prev;
    logic sck;
    logic sck_prev;
    logic [9:0] s_bus;
    logic [9:0] y_bus;
    logic [9:0] c_bus;
    logic [4:0] syncs;
    vipf_pkg::vipf_ddr_t ddr_ph;
    logic [9:0] ddr_luma;
    logic pix_valid;
    vipf_pkg::vipf_fmt_t fmt;
    logic [9:0] comp0;
    logic [9:0] comp1;
    logic [9:0] comp2;
    logic [2:0] sync_out;
    logic ext_sync;
    logic aux_valid;
    logic [9:0] aux_luma;
    logic [9:0] aux_chroma;
  } vipf_dev_state_t;

  vipf_dev_state_t q;
  vipf_dev_state_t d;

  logic [2:0] mode;
  logic swap;
  logic luma_on_fall;
  logic sd_wide;
  logic hd_wide;
  logic pri_rise;
  logic pri_fall;
  logic sec_rise;
  logic sec_fall;
  logic ddr_on;
  logic ddr_rise;
  logic ddr_fall;
  logic luma_edge;
  logic chroma_edge;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    d = q;
    d.pix_valid = 1'b0;
    d.aux_valid = 1'b0;
    if (i_cfg_we) begin
      case (i_cfg_addr)
        vipf_pkg::LOC_INPUT_CTRL: d.ctrl = i_cfg_wdata;
        vipf_pkg::LOC_HD_MODE: d.hd_mode = i_cfg_wdata;
        vipf_pkg::LOC_HD_RGB: d.hd_rgb = i_cfg_wdata;
        vipf_pkg::LOC_SD_RGB: d.sd_rgb = i_cfg_wdata;
        vipf_pkg::LOC_SD_MODE: d.sd_mode = i_cfg_wdata;
        default: d.ctrl = q.ctrl;
      endcase
    end
    // Link pins are registered once so clock level and data stay aligned
    d.pck = link.primary_pixel_clock_in;
    d.pck_prev = q.pck;
    d.sck = link.secondary_pixel_clock_in;
    d.sck_prev = q.sck;
    d.s_bus = link.s_bus;
    d.y_bus = link.y_bus;
    d.c_bus = link.c_bus;
    d.syncs = {link.sd_hsync_n, link.sd_vsync_n, link.pr_hsync_n, link.pr_vsync_n,
               link.pr_blank_n};

    mode = q.ctrl[vipf_pkg::MODE_MSB:vipf_pkg::MODE_LSB]; // RULE_01
    swap = q.ctrl[vipf_pkg::BUS_SWAP_BIT];
    // Only the low bit of the edge field matters; 11 also means luma on fall
    luma_on_fall = q.ctrl[vipf_pkg::EDGE_LSB]; // RULE_17 RULE_18
    sd_wide = q.sd_mode[vipf_pkg::SD_WIDE_BIT]; // RULE_11
    hd_wide = q.hd_mode[vipf_pkg::HD_WIDE_BIT]; // RULE_12
    pri_rise = q.pck & ~q.pck_prev;
    pri_fall = ~q.pck & q.pck_prev;
    sec_rise = q.sck & ~q.sck_prev;
    sec_fall = ~q.sck & q.sck_prev;

    case (mode)
      vipf_pkg::MODE_SD: begin // RULE_02
        if (pri_rise) begin // RULE_23
          d.pix_valid = 1'b1;
          d.sync_out = {q.syncs[4:3], 1'b1};
          d.comp2 = '0;
          if (q.sd_rgb[vipf_pkg::SD_RGB_BIT]) begin // RULE_07
            d.fmt = vipf_pkg::FMT_RGB;
            d.comp0 = vipf_pkg::trim(q.s_bus, sd_wide);
            d.comp1 = vipf_pkg::trim(q.y_bus, sd_wide);
            d.comp2 = vipf_pkg::trim(q.c_bus, sd_wide);
            d.ext_sync = 1'b1; // RULE_10
          end else if (q.sd_mode[vipf_pkg::SD_16_BIT]) begin // RULE_06 RULE_11
            d.fmt = vipf_pkg::FMT_YC422;
            d.comp0 = vipf_pkg::trim(swap ? q.y_bus : q.s_bus, sd_wide);
            d.comp1 = vipf_pkg::trim(swap ? q.c_bus : q.y_bus, sd_wide);
            d.ext_sync = 1'b1; // RULE_10
          end else begin
            d.fmt = vipf_pkg::FMT_INTERLEAVED;
            d.comp0 = vipf_pkg::trim(swap ? q.y_bus : q.s_bus, sd_wide); // RULE_05
            d.comp1 = '0;
            d.ext_sync = 1'b0;
          end
        end
      end
      vipf_pkg::MODE_HD_SDR: begin // RULE_03
        if (pri_rise) begin // RULE_23
          d.pix_valid = 1'b1;
          d.sync_out = q.syncs[2:0];
          d.comp0 = vipf_pkg::trim(q.y_bus, hd_wide);
          d.comp2 = '0;
          d.ext_sync = 1'b0;
          if (q.hd_rgb[vipf_pkg::HD_RGB_BIT]) begin // RULE_08
            d.fmt = vipf_pkg::FMT_RGB;
            d.comp0 = vipf_pkg::trim(q.s_bus, hd_wide);
            d.comp1 = vipf_pkg::trim(q.y_bus, hd_wide);
            d.comp2 = vipf_pkg::trim(q.c_bus, hd_wide);
            d.ext_sync = 1'b1; // RULE_10
          end else if (q.hd_mode[vipf_pkg::HD_422_BIT]) begin // RULE_13
            d.fmt = vipf_pkg::FMT_YC422;
            d.comp1 = vipf_pkg::trim(q.c_bus, hd_wide); // RULE_15
          end else begin
            d.fmt = vipf_pkg::FMT_YC444;
            d.comp1 = vipf_pkg::trim(q.s_bus, hd_wide); // RULE_14
            d.comp2 = vipf_pkg::trim(q.c_bus, hd_wide);
            d.ext_sync = 1'b1; // RULE_10
          end
        end
      end
      vipf_pkg::MODE_SIM_SDR, vipf_pkg::MODE_SIM_DDR: begin // RULE_21
        if (pri_rise) begin
          d.pix_valid = 1'b1;
          d.fmt = vipf_pkg::FMT_INTERLEAVED;
          d.sync_out = {q.syncs[4:3], 1'b1};
          d.comp0 = vipf_pkg::trim(q.s_bus, sd_wide);
          d.comp1 = '0;
          d.comp2 = '0;
          d.ext_sync = 1'b0;
        end
        if (mode == vipf_pkg::MODE_SIM_SDR && sec_rise) begin
          d.aux_valid = 1'b1;
          d.aux_luma = vipf_pkg::trim(q.y_bus, hd_wide);
          d.aux_chroma = vipf_pkg::trim(q.c_bus, hd_wide);
        end
      end
      vipf_pkg::MODE_ED54: begin // RULE_22
        if (pri_rise) begin
          d.pix_valid = 1'b1;
          d.fmt = vipf_pkg::FMT_INTERLEAVED;
          d.sync_out = q.syncs[2:0];
          d.comp0 = vipf_pkg::trim(q.y_bus, hd_wide);
          d.comp1 = '0;
          d.comp2 = '0;
          d.ext_sync = 1'b0;
        end
      end
      default: d.pix_valid = 1'b0;
    endcase

    // ****************************************************************
    // Dual data rate capture, always 4:2:2 on the Y bus
    // ****************************************************************
    ddr_on = (mode == vipf_pkg::MODE_HD_DDR) || (mode == vipf_pkg::MODE_SIM_DDR); // RULE_20
    ddr_rise = (mode == vipf_pkg::MODE_SIM_DDR) ? sec_rise : pri_rise;
    ddr_fall = (mode == vipf_pkg::MODE_SIM_DDR) ? sec_fall : pri_fall;
    luma_edge = luma_on_fall ? ddr_fall : ddr_rise; // RULE_16
    chroma_edge = luma_on_fall ? ddr_rise : ddr_fall; // RULE_16
    if (!ddr_on) begin
      d.ddr_ph = vipf_pkg::DDR_WAIT_Y;
    end else begin
      case (q.ddr_ph)
        vipf_pkg::DDR_WAIT_Y: begin
          if (luma_edge) begin
            d.ddr_luma = vipf_pkg::trim(q.y_bus, hd_wide);
            d.ddr_ph = vipf_pkg::DDR_HAVE_Y;
          end
        end
        vipf_pkg::DDR_HAVE_Y: begin
          if (chroma_edge) begin
            d.ddr_ph = vipf_pkg::DDR_WAIT_Y;
            if (mode == vipf_pkg::MODE_SIM_DDR) begin
              d.aux_valid = 1'b1;
              d.aux_luma = q.ddr_luma;
              d.aux_chroma = vipf_pkg::trim(q.y_bus, hd_wide);
            end else begin
              d.pix_valid = 1'b1;
              d.fmt = vipf_pkg::FMT_YC422;
              d.sync_out = q.syncs[2:0];
              d.comp0 = q.ddr_luma;
              d.comp1 = vipf_pkg::trim(q.y_bus, hd_wide);
              d.comp2 = '0;
              d.ext_sync = 1'b0;
            end
          end else if (luma_edge) begin
            d.ddr_luma = vipf_pkg::trim(q.y_bus, hd_wide);
          end
        end
        default: d.ddr_ph = vipf_pkg::DDR_WAIT_Y;
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q <= '0;
      q.ctrl <= vipf_pkg::CFG_RESET; // RULE_01
      q.ddr_ph <= vipf_pkg::DDR_WAIT_Y;
      q.sync_out <= 3'h7;
      q.syncs <= 5'h1f;
    end else begin
      q <= d;
    end
  end

  assign o_input_mode = q.ctrl[vipf_pkg::MODE_MSB:vipf_pkg::MODE_LSB];
  assign o_pix_valid = q.pix_valid;
  assign o_pix_fmt = q.fmt;
  assign o_comp0 = q.comp0;
  assign o_comp1 = q.comp1;
  assign o_comp2 = q.comp2;
  assign o_hsync_n = q.sync_out[2];
  assign o_vsync_n = q.sync_out[1];
  assign o_blank_n = q.sync_out[0];
  assign o_ext_sync_only = q.ext_sync;
  assign o_aux_valid = q.aux_valid;
  assign o_aux_luma = q.aux_luma;
  assign o_aux_chroma = q.aux_chroma;

endmodule

`default_nettype wire

// file: vipf_source.sv
// Video source end: divides the system clock into pixel clocks and drives buses and syncs.
// Assumes the user keeps its words steady until the matching take pulse.
`timescale 1ns/1ps
`default_nettype none

module vipf_source (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  vipf_link_if.src link,
  input wire logic i_ddr_en,
  input wire logic i_sim_en,
  input wire logic i_luma_on_fall,
  input wire logic [9:0] i_s_word,
  input wire logic [9:0] i_y_word,
  input wire logic [9:0] i_c_word,
  input wire logic i_hsync_n,
  input wire logic i_vsync_n,
  input wire logic i_blank_n,
  output logic o_take_pri,
  output logic o_take_sec
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [2:0] pcnt;
    logic [2:0] scnt;
    logic pck;
    logic sck;
    logic [9:0] s_bus;
    logic [9:0] y_bus;
    logic [9:0] c_bus;
    logic [9:0] chroma_hold;
    logic [4:0] syncs;
    logic take_pri;
    logic take_sec;
  } vipf_src_state_t;

  vipf_src_state_t q;
  vipf_src_state_t d;

  logic p_rise;
  logic p_fall;
  logic s_rise;
  logic s_fall;
  logic hd_rise;
  logic hd_fall;

  always_comb begin
    d = q;
    d.take_pri = 1'b0;
    d.take_sec = 1'b0;
    p_rise = (q.pcnt == 3'h0);
    p_fall = (q.pcnt == vipf_pkg::PRI_HALF);
    s_rise = (q.scnt == 3'h0);
    s_fall = (q.scnt == vipf_pkg::SEC_HALF);
    d.pcnt = (q.pcnt == 3'((2 * vipf_pkg::PRI_HALF) - 1)) ? 3'h0 : q.pcnt + 3'h1;
    d.scnt = (q.scnt == 3'((2 * vipf_pkg::SEC_HALF) - 1)) ? 3'h0 : q.scnt + 3'h1;
    if (p_rise) d.pck = 1'b1; // RULE_04 RULE_19
    if (p_fall) d.pck = 1'b0;
    if (s_rise) d.sck = 1'b1;
    if (s_fall) d.sck = 1'b0;
    hd_rise = i_sim_en ? s_rise : p_rise;
    hd_fall = i_sim_en ? s_fall : p_fall;

    // SD side, plus HD syncs when not simultaneous and Y/C buses when also not dual rate, moves with the primary rise
    if (p_rise) begin
      d.s_bus = i_s_word;
      d.syncs[4:3] = {i_hsync_n, i_vsync_n};
      if (!i_sim_en) begin
        d.syncs[2:0] = {i_hsync_n, i_vsync_n, i_blank_n};
        if (!i_ddr_en) begin
          d.y_bus = i_y_word;
          d.c_bus = i_c_word;
        end
      end
      if (!(i_ddr_en && !i_sim_en && i_luma_on_fall)) d.take_pri = 1'b1;
    end
    if (i_sim_en && !i_ddr_en && s_rise) begin
      d.y_bus = i_y_word;
      d.c_bus = i_c_word;
      d.syncs[2:0] = {i_hsync_n, i_vsync_n, i_blank_n};
      d.take_sec = 1'b1;
    end
    // Dual rate: luma on the chosen edge, held chroma on the other
    if (i_ddr_en) begin
      if (i_luma_on_fall ? hd_fall : hd_rise) begin // RULE_18
        d.y_bus = i_y_word;
        d.chroma_hold = i_c_word;
        d.syncs[2:0] = {i_hsync_n, i_vsync_n, i_blank_n};
        if (i_sim_en) d.take_sec = 1'b1;
        else if (i_luma_on_fall) d.take_pri = 1'b1;
      end else if (i_luma_on_fall ? hd_rise : hd_fall) begin
        d.y_bus = q.chroma_hold;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q <= '0;
      q.syncs <= 5'h1f;
    end else begin
      q <= d;
    end
  end

  assign link.primary_pixel_clock_in = q.pck;
  assign link.secondary_pixel_clock_in = q.sck;
  assign link.s_bus = q.s_bus;
  assign link.y_bus = q.y_bus;
  assign link.c_bus = q.c_bus;
  assign link.sd_hsync_n = q.syncs[4];
  assign link.sd_vsync_n = q.syncs[3];
  assign link.pr_hsync_n = q.syncs[2];
  assign link.pr_vsync_n = q.syncs[1];
  assign link.pr_blank_n = q.syncs[0];
  assign o_take_pri = q.take_pri;
  assign o_take_sec = q.take_sec;

endmodule

`default_nettype wire

// file: vipf_link_props.sv
// Checker for the pixel link between the video source and the input port.
// Assumes it sees the link signals with the shared system clock and reset.
`timescale 1ns/1ps
`default_nettype none

module vipf_link_props (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic primary_pixel_clock_in,
  input wire logic secondary_pixel_clock_in,
  input wire logic [9:0] s_bus,
  input wire logic [9:0] y_bus,
  input wire logic [9:0] c_bus,
  input wire logic sd_hsync_n,
  input wire logic sd_vsync_n,
  input wire logic pr_hsync_n,
  input wire logic pr_vsync_n,
  input wire logic pr_blank_n
);
  // ****************************
  // Link clock shape and timing
  // ****************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_pri_high;
    primary_pixel_clock_in[*2] ##1 !primary_pixel_clock_in;
  endsequence
  sequence s_pri_low;
    !primary_pixel_clock_in[*2] ##1 primary_pixel_clock_in;
  endsequence
  sequence s_sec_cycle;
    secondary_pixel_clock_in[*3] ##1 !secondary_pixel_clock_in[*3] ##1 secondary_pixel_clock_in;
  endsequence

  property p_pri_high;
    $rose(primary_pixel_clock_in) |-> s_pri_high;
  endproperty
  property p_pri_low;
    $fell(primary_pixel_clock_in) |-> s_pri_low;
  endproperty
  property p_sec_cycle;
    $rose(secondary_pixel_clock_in) |-> s_sec_cycle;
  endproperty
  property p_s_bus;
    $changed(s_bus) |-> $changed(primary_pixel_clock_in);
  endproperty
  property p_y_bus;
    $changed(y_bus) |-> $changed(primary_pixel_clock_in) || $changed(secondary_pixel_clock_in);
  endproperty
  property p_c_bus;
    $changed(c_bus) |-> $rose(primary_pixel_clock_in) || $rose(secondary_pixel_clock_in);
  endproperty
  property p_sd_sync;
    $changed(sd_hsync_n) || $changed(sd_vsync_n) |-> $changed(primary_pixel_clock_in);
  endproperty
  property p_pr_sync;
    $changed(pr_hsync_n) || $changed(pr_vsync_n) || $changed(pr_blank_n)
      |-> $changed(primary_pixel_clock_in) || $changed(secondary_pixel_clock_in);
  endproperty

  a_pri_high: assert property (p_pri_high) else $error("primary high phase wrong");
  a_pri_low: assert property (p_pri_low) else $error("primary low phase wrong");
  a_sec_cycle: assert property (p_sec_cycle) else $error("secondary period wrong");
  a_s_bus: assert property (p_s_bus) else $error("first bus moved off clock");
  a_y_bus: assert property (p_y_bus) else $error("second bus moved off clock");
  a_c_bus: assert property (p_c_bus) else $error("third bus moved off rise");
  a_sd_sync: assert property (p_sd_sync) else $error("sd sync moved off clock");
  a_pr_sync: assert property (p_pr_sync) else $error("pr sync moved off clock");
endmodule

`default_nettype wire

// file: tb_video_input_port_formatter.sv
// Self-checking bench joining source and input port over the pixel link.
// Assumes the package, link interface and both design ends are compiled first.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); \
    end \
  end

module tb_video_input_port_formatter;
  // ****************************
  // Bench signals and instances
  // ****************************
  localparam logic [9:0] WS = 10'h2a7;
  localparam logic [9:0] WY = 10'h1d3;
  localparam logic [9:0] WC = 10'h35e;
  localparam logic [9:0] N8 = 10'h3fc;
  logic clk, rst, we, ddr_en, sim_en, fall, hs, hs_v;
  logic bl, bl_v, sd_blank;
  logic [7:0] addr, wdata;
  logic [2:0] mode;
  logic [1:0] fmt;
  logic pv, ho, vo, bo, ext, av, tp, ts;
  logic [9:0] c0, c1, c2, al, ac;
  int err_total, total_checks, cyc;

  vipf_link_if link();
  vipf_source i_vipf_source (.i_clk(clk), .i_sys_rst(rst), .link(link), .i_ddr_en(ddr_en),
    .i_sim_en(sim_en), .i_luma_on_fall(fall), .i_s_word(WS), .i_y_word(WY), .i_c_word(WC),
    .i_hsync_n(hs), .i_vsync_n(~hs), .i_blank_n(bl), .o_take_pri(tp), .o_take_sec(ts));
  vipf_device i_vipf_device (.i_clk(clk), .i_sys_rst(rst), .link(link), .i_cfg_we(we),
    .i_cfg_addr(addr), .i_cfg_wdata(wdata), .o_input_mode(mode), .o_pix_valid(pv),
    .o_pix_fmt(fmt), .o_comp0(c0), .o_comp1(c1), .o_comp2(c2), .o_hsync_n(ho),
    .o_vsync_n(vo), .o_blank_n(bo), .o_ext_sync_only(ext), .o_aux_valid(av),
    .o_aux_luma(al), .o_aux_chroma(ac));
  vipf_link_props i_vipf_link_props (.i_clk(clk), .i_sys_rst(rst),
    .primary_pixel_clock_in(link.primary_pixel_clock_in),
    .secondary_pixel_clock_in(link.secondary_pixel_clock_in),
    .s_bus(link.s_bus), .y_bus(link.y_bus), .c_bus(link.c_bus),
    .sd_hsync_n(link.sd_hsync_n), .sd_vsync_n(link.sd_vsync_n),
    .pr_hsync_n(link.pr_hsync_n), .pr_vsync_n(link.pr_vsync_n),
    .pr_blank_n(link.pr_blank_n));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      finish_test();
    end
  end

  task automatic cfg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask

  task automatic setsrc(input logic d, input logic s, input logic f);
    @(posedge clk);
    ddr_en <= d;
    sim_en <= s;
    fall <= f;
  endtask

  // Index 0 take_pri, 1 take_sec, 2 pix_valid, 3 aux_valid
  task automatic wait_pulse(input int k);
    int n;
    logic [3:0] v;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      v = {av, pv, ts, tp};
      n++;
    end while (v[k] !== 1'b1 && n < 20);
    `CHK(v[k], 1'b1)
  endtask

  // Second take carries the current words whatever the phase at entry
  task automatic px(input bit aux, input logic [9:0] e0, input logic [9:0] e1,
                    input logic [9:0] e2, input logic [1:0] ef);
    hs_v = ~hs_v;
    if (hs_v) bl_v = ~bl_v;
    @(posedge clk);
    hs <= hs_v;
    bl <= bl_v;
    wait_pulse(int'(aux));
    wait_pulse(int'(aux));
    wait_pulse(aux ? 3 : 2);
    if (aux) begin
      `CHK(al, e0)
      `CHK(ac, e1)
    end else begin
      `CHK(c0, e0)
      `CHK(c1, e1)
      `CHK(c2, e2)
      `CHK(fmt, ef)
      `CHK(ho, hs_v)
      `CHK(vo, ~hs_v)
      `CHK(bo, sd_blank | bl_v)
    end
  endtask

  task automatic done(input string n);
    $display("test %s done, mismatches %0d", n, err_total);
  endtask

  initial begin
    rst = 1'b1;
    we = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    ddr_en = 1'b0;
    sim_en = 1'b0;
    fall = 1'b0;
    hs = 1'b1;
    hs_v = 1'b1;
    bl = 1'b1;
    bl_v = 1'b1;
    sd_blank = 1'b1;
    err_total = 0;
    total_checks = 0;
    cyc = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1;
    `CHK(mode, vipf_pkg::MODE_SD)
    px(0, WS & N8, 10'h000, 10'h000, vipf_pkg::FMT_INTERLEAVED);
    cfg(vipf_pkg::LOC_INPUT_CTRL, 8'h80);
    px(0, WY & N8, 10'h000, 10'h000, vipf_pkg::FMT_INTERLEAVED);
    cfg(vipf_pkg::LOC_SD_MODE, 8'h18);
    px(0, WY, WC, 10'h000, vipf_pkg::FMT_YC422);
    `CHK(ext, 1'b1)
    cfg(vipf_pkg::LOC_INPUT_CTRL, 8'h00);
    px(0, WS, WY, 10'h000, vipf_pkg::FMT_YC422);
    cfg(vipf_pkg::LOC_SD_RGB, 8'h80);
    px(0, WS, WY, WC, vipf_pkg::FMT_RGB);
    done("sd_only");
    cfg(8'h02, 8'h20);
    #1;
    `CHK(mode, vipf_pkg::MODE_SD)
    cfg(vipf_pkg::LOC_INPUT_CTRL, 8'h10);
    #1;
    `CHK(mode, vipf_pkg::MODE_HD_SDR)
    sd_blank = 1'b0;
    cfg(vipf_pkg::LOC_HD_MODE, 8'h40);
    px(0, WY & N8, WC & N8, 10'h000, vipf_pkg::FMT_YC422);
    `CHK(ext, 1'b0)
    cfg(vipf_pkg::LOC_HD_MODE, 8'h04);
    px(0, WY, WS, WC, vipf_pkg::FMT_YC444);
    cfg(vipf_pkg::LOC_HD_RGB, 8'h02);
    px(0, WS, WY, WC, vipf_pkg::FMT_RGB);
    done("hd_sdr");
    setsrc(1'b1, 1'b0, 1'b0);
    cfg(vipf_pkg::LOC_INPUT_CTRL, 8'h20);
    #1;
    `CHK(mode, vipf_pkg::MODE_HD_DDR)
    px(0, WY, WC, 10'h000, vipf_pkg::FMT_YC422);
    setsrc(1'b1, 1'b0, 1'b1);
    cfg(vipf_pkg::LOC_INPUT_CTRL, 8'h26);
    px(0, WY, WC, 10'h000, vipf_pkg::FMT_YC422);
    done("hd_ddr");
    cfg(vipf_pkg::LOC_SD_RGB, 8'h00);
    cfg(vipf_pkg::LOC_SD_MODE, 8'h10);
    cfg(vipf_pkg::LOC_HD_RGB, 8'h00);
    setsrc(1'b0, 1'b1, 1'b0);
    cfg(vipf_pkg::LOC_INPUT_CTRL, 8'h30);
    sd_blank = 1'b1;
    px(0, WS, 10'h000, 10'h000, vipf_pkg::FMT_INTERLEAVED);
    px(1, WY, WC, 10'h000, vipf_pkg::FMT_INTERLEAVED);
    setsrc(1'b1, 1'b1, 1'b0);
    cfg(vipf_pkg::LOC_INPUT_CTRL, 8'h40);
    px(1, WY, WC, 10'h000, vipf_pkg::FMT_INTERLEAVED);
    px(0, WS, 10'h000, 10'h000, vipf_pkg::FMT_INTERLEAVED);
    done("simultaneous");
    sd_blank = 1'b0;
    setsrc(1'b0, 1'b0, 1'b0);
    cfg(vipf_pkg::LOC_INPUT_CTRL, 8'h70);
    px(0, WY, 10'h000, 10'h000, vipf_pkg::FMT_INTERLEAVED);
    done("ed_only");
    finish_test();
  end
endmodule

`default_nettype wire
